/* irt_pkg.sv */
// shared constants and types of the infrared dual counter/timer
package irt_pkg;
  localparam int AW = 8;
  localparam logic [7:0] OFS_BCTL = 8'h00;
  localparam logic [7:0] OFS_SCTL = 8'h04;
  localparam logic [7:0] OFS_WCTL = 8'h08;
  localparam logic [7:0] OFS_BRH = 8'h0C;
  localparam logic [7:0] OFS_BRL = 8'h10;
  localparam logic [7:0] OFS_WRU = 8'h14;
  localparam logic [7:0] OFS_WRL = 8'h18;
  localparam logic [7:0] OFS_BCR = 8'h1C;
  localparam logic [7:0] OFS_BCF = 8'h20;
  localparam logic [7:0] OFS_WCU = 8'h24;
  localparam logic [7:0] OFS_WCL = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PP = 2'h1;
  localparam logic [1:0] SUB_F0 = 2'h2;
  localparam logic [1:0] SUB_F1 = 2'h3;
  localparam logic [1:0] CMB_AND = 2'h0;
  localparam logic [1:0] CMB_OR = 2'h1;
  localparam logic [1:0] CMB_NOR = 2'h2;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  localparam logic [7:0] B_ONE = 8'h01;
  localparam logic [7:0] B_FULL = 8'hFF;
  localparam logic [15:0] W_ONE = 16'h0001;
  localparam logic [15:0] W_FULL = 16'hFFFF;
  localparam logic [4:0] GF_ONE = 5'h01;
  // glitch widths in system clocks per filter code
  localparam logic [4:0] GF_W0 = 5'h00;
  localparam logic [4:0] GF_W1 = 5'h04;
  localparam logic [4:0] GF_W2 = 5'h08;
  localparam logic [4:0] GF_W3 = 5'h10;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  typedef struct packed {
    logic en;
    logic single;
    logic tout;
    logic [1:0] clk;
    logic cap_ie;
    logic to_ie;
    logic pin_sel;
  } irt_ctrl_type;
  typedef struct packed {
    logic demod;
    logic route;
    logic [1:0] comb;
    logic [1:0] sub;
    logic init_b;
    logic init_w;
  } irt_shared_type;
  typedef enum {IRT_STOPPED, IRT_ARMED, IRT_RUNNING} irt_phase_type;
endpackage

/* irt_timer.sv */
// infrared dual counter/timer with axi4-lite registers
// Overview of operation
// - edge detector pulses on rising or falling edge per edge-select field
// - pulses narrower than glitch-filter width are dropped before edge detection
// - disabled byte timer in transmit drives inverse of its initial bit
// - on enable byte output takes initial value; loads low reload if 0
// - single-pass byte timer stops at zero, toggles, sets timeout, interrupts
// - modulo-N byte timer toggles, flags timeout, reloads per output level
// - reload writes take effect only at the next counter load
// - byte count of one forbidden; zero wraps to FFh without timeout
// - demod byte timer starts at first edge, captures complement per edge
// - byte capture sets edge flag, interrupts if enabled, reloads FFh
// - byte timer zero in demod flags timeout and continues from FFh
// - submode 10/11 forces word output low/high; else disabled inverse initial
// - word timer zero toggles, flags, interrupts; stops or reloads per mode
// - word count of one forbidden; zero wraps to FFFFh without timeout
// - demod word timer captures, reloads and starts at first edge
// - with ignore bit clear each edge captures complement, flags, reloads FFFFh
// - with ignore bit set byte timeouts capture word count without reload
// - writing ignore bit zero then one re-arms capture on next edge
// - word timer zero in demod flags timeout and continues from FFFFh
// - ping-pong hands enable between timers at terminal count; 00 stops
// - pins carry timer outputs when selected; combined pin uses chosen logic
// - mode bit selects transmit when 0, demodulation when 1
// - demod edge flags set by hardware, cleared only by writing one
`timescale 1ns/1ps
`default_nettype none
module irt_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic capture_input_main,
  input wire logic capture_input_alt,
  output logic byte_output_pin,
  output logic byte_output_sel,
  output logic word_output_pin,
  output logic word_output_sel,
  output logic combined_output_pin,
  output logic combined_output_sel,
  output logic byte_timeout_irq,
  output logic byte_capture_irq,
  output logic word_timeout_irq,
  output logic word_capture_irq
);
  irt_pkg::irt_ctrl_type bctl, wctl, wb, ww;
  irt_pkg::irt_shared_type sh, ws;
  irt_pkg::irt_phase_type bph, wph;
  logic aw_full, w_full, wr_fire;
  logic [7:0] aw_q, wd;
  logic ws0;
  logic [7:0] brh, brl, wru, wrl, bcr, bcf, wcu, wcl;
  logic [7:0] bcnt;
  logic [15:0] wcnt;
  logic bout, wout, w_rearm;
  logic [2:0] pre;
  logic btick, wtick;
  logic [1:0] in_main_s, in_alt_s;
  logic flt, rise_evt, fall_evt;
  logic [4:0] fcnt, fwid;
  logic brp, bfp, wrp, wfp;
  logic bedge, wedge, pp, dem;
  logic b_run, b_term, b_cap, b_start, b_stop;
  logic w_run, w_first, w_ecap, w_rcap, w_hcap;
  logic w_cap, w_rld, w_term, w_start, w_stop;
  logic t8_lvl, t16_lvl, cmb;
  logic wr_bctl, wr_sctl, wr_wctl;
  logic rise_set, fall_set;

  function automatic logic tick_of(input logic [1:0] s, input logic [2:0] p);
    case (s)
      irt_pkg::DIV1: tick_of = 1'b1;
      irt_pkg::DIV2: tick_of = p[0];
      irt_pkg::DIV4: tick_of = &p[1:0];
      default: tick_of = &p;
    endcase
  endfunction

  // ---- axi4-lite slave: address and data taken in either order
  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;
  assign wr_fire = aw_full && w_full && !bvalid;
  assign wb = irt_pkg::irt_ctrl_type'(wd);
  assign ww = irt_pkg::irt_ctrl_type'(wd);
  assign ws = irt_pkg::irt_shared_type'(wd);
  assign wr_bctl = wr_fire && ws0 && aw_q == irt_pkg::OFS_BCTL;
  assign wr_sctl = wr_fire && ws0 && aw_q == irt_pkg::OFS_SCTL;
  assign wr_wctl = wr_fire && ws0 && aw_q == irt_pkg::OFS_WCTL;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a <= irt_pkg::OFS_WCL && a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= irt_pkg::REG_RST;
      wd <= irt_pkg::REG_RST;
      ws0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_q <= awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wd <= wdata[7:0];
        ws0 <= wstrb[0];
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= irt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_q) ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= irt_pkg::RD_ZERO;
      rresp <= irt_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
      case (araddr)
        irt_pkg::OFS_BCTL: rdata <= 32'(bctl);
        irt_pkg::OFS_SCTL: rdata <= 32'(sh);
        irt_pkg::OFS_WCTL: rdata <= 32'(wctl);
        irt_pkg::OFS_BRH: rdata <= 32'(brh);
        irt_pkg::OFS_BRL: rdata <= 32'(brl);
        irt_pkg::OFS_WRU: rdata <= 32'(wru);
        irt_pkg::OFS_WRL: rdata <= 32'(wrl);
        irt_pkg::OFS_BCR: rdata <= 32'(bcr);
        irt_pkg::OFS_BCF: rdata <= 32'(bcf);
        irt_pkg::OFS_WCU: rdata <= 32'(wcu);
        irt_pkg::OFS_WCL: rdata <= 32'(wcl);
        default: rdata <= irt_pkg::RD_ZERO;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // reload registers only store; the counters read them when they load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brh <= irt_pkg::REG_RST;
      brl <= irt_pkg::REG_RST;
      wru <= irt_pkg::REG_RST;
      wrl <= irt_pkg::REG_RST;
    end else if (wr_fire && ws0) begin
      if (aw_q == irt_pkg::OFS_BRH) brh <= wd;
      if (aw_q == irt_pkg::OFS_BRL) brl <= wd;
      if (aw_q == irt_pkg::OFS_WRU) wru <= wd;
      if (aw_q == irt_pkg::OFS_WRL) wrl <= wd;
    end
  end

  // ---- shared control; in demod the two low bits are edge flags
  assign dem = sh.demod;
  assign pp = !dem && sh.sub == irt_pkg::SUB_PP;
  assign rise_set = (b_cap && brp) || ((w_ecap || w_rcap) && wrp);
  assign fall_set = (b_cap && bfp) || ((w_ecap || w_rcap) && wfp);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh <= irt_pkg::irt_shared_type'(irt_pkg::REG_RST);
    end else begin
      if (wr_sctl) begin
        sh.demod <= ws.demod;
        sh.route <= ws.route;
        sh.comb <= ws.comb;
        sh.sub <= ws.sub;
      end
      if (dem) begin
        // a new edge wins over a clear in the same cycle
        if (rise_set) sh.init_b <= 1'b1;
        else if (wr_sctl && ws.init_b) sh.init_b <= 1'b0;
        if (fall_set) sh.init_w <= 1'b1;
        else if (wr_sctl && ws.init_w) sh.init_w <= 1'b0;
      end else if (wr_sctl) begin
        sh.init_b <= ws.init_b;
        sh.init_w <= ws.init_w;
      end
    end
  end

  // ---- per-timer control registers, status set wins over clear
  assign b_start = (wr_bctl && wb.en && !bctl.en) || (pp && w_term);
  assign w_start = (wr_wctl && ww.en && !wctl.en) || (pp && b_term);
  assign b_stop = b_term && !dem && (bctl.single || pp);
  assign w_stop = w_term && !dem && (wctl.single || pp);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bctl <= irt_pkg::irt_ctrl_type'(irt_pkg::REG_RST);
    end else begin
      if (wr_bctl) begin
        bctl.single <= wb.single;
        bctl.clk <= wb.clk;
        bctl.cap_ie <= wb.cap_ie;
        bctl.to_ie <= wb.to_ie;
        bctl.pin_sel <= wb.pin_sel;
      end
      if (b_stop) bctl.en <= 1'b0;
      else if (b_start) bctl.en <= 1'b1;
      else if (wr_bctl && !wb.en) bctl.en <= 1'b0;
      if (b_term) bctl.tout <= 1'b1;
      else if (wr_bctl && wb.tout) bctl.tout <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wctl <= irt_pkg::irt_ctrl_type'(irt_pkg::REG_RST);
    end else begin
      if (wr_wctl) begin
        wctl.single <= ww.single;
        wctl.clk <= ww.clk;
        wctl.cap_ie <= ww.cap_ie;
        wctl.to_ie <= ww.to_ie;
        wctl.pin_sel <= ww.pin_sel;
      end
      if (w_stop) wctl.en <= 1'b0;
      else if (w_start) wctl.en <= 1'b1;
      else if (wr_wctl && !ww.en) wctl.en <= 1'b0;
      if (w_term) wctl.tout <= 1'b1;
      else if (wr_wctl && ww.tout) wctl.tout <= 1'b0;
    end
  end

  // ---- prescaler shared by both timers
  always_ff @(posedge aclk) begin
    if (!aresetn) pre <= '0;
    else pre <= pre + 3'h1;
  end
  assign btick = tick_of(bctl.clk, pre);
  assign wtick = tick_of(wctl.clk, pre);

  // ---- input path: synchroniser, glitch filter, edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_main_s <= '0;
      in_alt_s <= '0;
    end else begin
      in_main_s <= {in_main_s[0], capture_input_main};
      in_alt_s <= {in_alt_s[0], capture_input_alt};
    end
  end

  always_comb begin
    case (sh.sub)
      2'h0: fwid = irt_pkg::GF_W0;
      2'h1: fwid = irt_pkg::GF_W1;
      2'h2: fwid = irt_pkg::GF_W2;
      default: fwid = irt_pkg::GF_W3;
    endcase
  end

  // a level must stay changed past the width before it is believed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt <= 1'b0;
      fcnt <= '0;
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
    end else begin
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
      if ((sh.route ? in_alt_s[1] : in_main_s[1]) == flt) begin
        fcnt <= '0;
      end else if (fcnt >= fwid) begin
        flt <= !flt;
        fcnt <= '0;
        rise_evt <= dem && !flt && sh.comb[0];
        fall_evt <= dem && flt && sh.comb[1];
      end else begin
        fcnt <= fcnt + irt_pkg::GF_ONE;
      end
    end
  end

  // edges wait for the owning timer's tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brp <= 1'b0;
      bfp <= 1'b0;
      wrp <= 1'b0;
      wfp <= 1'b0;
    end else begin
      brp <= (brp && !btick) || rise_evt;
      bfp <= (bfp && !btick) || fall_evt;
      wrp <= (wrp && !wtick) || rise_evt;
      wfp <= (wfp && !wtick) || fall_evt;
    end
  end
  assign bedge = btick && dem && (brp || bfp);
  assign wedge = wtick && dem && (wrp || wfp);

  // ---- byte timer
  assign b_run = bph == irt_pkg::IRT_RUNNING && bctl.en;
  assign b_cap = bedge && b_run;
  // a count of zero wraps without a timeout
  assign b_term = btick && b_run && bcnt == irt_pkg::B_ONE && !b_cap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt <= '0;
      bout <= 1'b0;
      bph <= irt_pkg::IRT_STOPPED;
    end else if (b_start) begin
      bout <= sh.init_b;
      bcnt <= dem ? irt_pkg::B_FULL : (sh.init_b ? brh : brl);
      bph <= dem ? irt_pkg::IRT_ARMED : irt_pkg::IRT_RUNNING;
    end else if (!bctl.en) begin
      bph <= irt_pkg::IRT_STOPPED;
    end else if (btick) begin
      case (bph)
        irt_pkg::IRT_ARMED: begin
          if (bedge) begin
            bph <= irt_pkg::IRT_RUNNING;
            bcnt <= irt_pkg::B_FULL;
          end
        end
        irt_pkg::IRT_RUNNING: begin
          if (b_cap) begin
            bcnt <= irt_pkg::B_FULL;
          end else if (b_term && !dem && !bctl.single && !pp) begin
            bout <= !bout;
            bcnt <= bout ? brl : brh;
          end else begin
            if (b_term && !dem) bout <= !bout;
            bcnt <= bcnt - irt_pkg::B_ONE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcr <= irt_pkg::REG_RST;
      bcf <= irt_pkg::REG_RST;
    end else if (b_cap) begin
      if (brp) bcr <= ~bcnt;
      if (bfp) bcf <= ~bcnt;
    end
  end

  // ---- word timer
  assign w_run = wph == irt_pkg::IRT_RUNNING && wctl.en;
  assign w_first = wedge && wph == irt_pkg::IRT_ARMED && wctl.en;
  assign w_ecap = wedge && w_run && !wctl.single;
  assign w_rcap = wedge && w_run && wctl.single && w_rearm;
  assign w_hcap = b_term && dem && w_run && wctl.single;
  assign w_rld = w_first || w_ecap || w_rcap;
  assign w_cap = w_rld || w_hcap;
  assign w_term = wtick && w_run && wcnt == irt_pkg::W_ONE && !w_rld;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt <= '0;
      wout <= 1'b0;
      wph <= irt_pkg::IRT_STOPPED;
    end else if (w_start) begin
      wout <= sh.init_w;
      wcnt <= dem ? irt_pkg::W_FULL : {wru, wrl};
      wph <= dem ? irt_pkg::IRT_ARMED : irt_pkg::IRT_RUNNING;
    end else if (!wctl.en) begin
      wph <= irt_pkg::IRT_STOPPED;
    end else if (w_rld) begin
      wcnt <= irt_pkg::W_FULL;
      wph <= irt_pkg::IRT_RUNNING;
    end else if (wtick && w_run) begin
      if (w_term && !dem) wout <= !wout;
      if (w_term && !dem && !wctl.single && !pp) wcnt <= {wru, wrl};
      else wcnt <= wcnt - irt_pkg::W_ONE;
    end
  end

  // re-arm on a zero-to-one write of the ignore bit
  always_ff @(posedge aclk) begin
    if (!aresetn) w_rearm <= 1'b0;
    else if (w_start || w_rcap) w_rearm <= 1'b0;
    else if (wr_wctl && ww.single && !wctl.single) w_rearm <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcu <= irt_pkg::REG_RST;
      wcl <= irt_pkg::REG_RST;
    end else if (w_cap) begin
      {wcu, wcl} <= ~wcnt;
    end
  end

  // ---- interrupt requests, one-cycle pulses gated by the masks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_timeout_irq <= 1'b0;
      byte_capture_irq <= 1'b0;
      word_timeout_irq <= 1'b0;
      word_capture_irq <= 1'b0;
    end else begin
      byte_timeout_irq <= b_term && bctl.to_ie;
      byte_capture_irq <= b_cap && bctl.cap_ie;
      word_timeout_irq <= w_term && wctl.to_ie;
      word_capture_irq <= w_cap && wctl.cap_ie;
    end
  end

  // ---- output logic
  assign t8_lvl = (!dem && !bctl.en) ? !sh.init_b : bout;
  always_comb begin
    if (!dem && sh.sub == irt_pkg::SUB_F0) t16_lvl = 1'b0;
    else if (!dem && sh.sub == irt_pkg::SUB_F1) t16_lvl = 1'b1;
    else if (!dem && !wctl.en) t16_lvl = !sh.init_w;
    else t16_lvl = wout;
    case (sh.comb)
      irt_pkg::CMB_AND: cmb = t8_lvl & t16_lvl;
      irt_pkg::CMB_OR: cmb = t8_lvl | t16_lvl;
      irt_pkg::CMB_NOR: cmb = !(t8_lvl | t16_lvl);
      default: cmb = !(t8_lvl & t16_lvl);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_output_pin <= 1'b0;
      word_output_pin <= 1'b0;
      combined_output_pin <= 1'b0;
      byte_output_sel <= 1'b0;
      word_output_sel <= 1'b0;
      combined_output_sel <= 1'b0;
    end else begin
      byte_output_pin <= t8_lvl;
      word_output_pin <= t16_lvl;
      combined_output_pin <= cmb;
      byte_output_sel <= bctl.pin_sel;
      word_output_sel <= wctl.pin_sel;
      combined_output_sel <= !dem && sh.route;
    end
  end

  // ---- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_two_idle;
    (aresetn && !dem && !bctl.en && !b_start) [*2];
  endsequence

  chk_byte_low_load: assert property (
    (b_start && !dem && !sh.init_b) |=> bcnt == $past(brl) && bout == 1'b0)
    else $error("byte timer did not load low reload");
  chk_byte_idle_out: assert property (
    s_two_idle |-> byte_output_pin == !$past(sh.init_b))
    else $error("idle byte output not inverse of initial");
  chk_byte_wrap: assert property (
    (btick && b_run && bcnt == '0 && !b_cap) |-> !b_term ##1 bcnt == irt_pkg::B_FULL)
    else $error("byte wrap misbehaved");
  chk_byte_timeout: assert property (
    (b_term && !dem) |=> bctl.tout && bout != $past(bout))
    else $error("byte timeout did not toggle and flag");
  chk_edge_flag: assert property (
    (dem && rise_set) |=> sh.init_b)
    else $error("rise flag lost");
  chk_word_force: assert property (
    (!dem && sh.sub == irt_pkg::SUB_F1) [*2] |-> word_output_pin)
    else $error("word output not forced high");
  chk_word_capture: assert property (
    w_ecap |=> {wcu, wcl} == ~$past(wcnt) && wcnt == irt_pkg::W_FULL)
    else $error("word edge capture wrong");
  chk_word_hold: assert property (
    (w_hcap && !wtick && !w_rld) |=> wcnt == $past(wcnt) && {wcu, wcl} == ~$past(wcnt))
    else $error("word hold capture wrong");
  chk_pp_swap: assert property (
    (b_term && pp && !wctl.en) |=> !bctl.en && wctl.en && wph == irt_pkg::IRT_RUNNING)
    else $error("ping-pong hand-over failed");
endmodule
`default_nettype wire

/* irt_ir_far.sv */
// infrared receiver model that drives the capture inputs
`timescale 1ns/1ps
`default_nettype none
module irt_ir_far (
  input wire logic aclk,
  output logic capture_input_main,
  output logic capture_input_alt
);
  initial begin
    capture_input_main = 1'h0;
    capture_input_alt = 1'h1;
  end
  // one carrier burst; level is held between edges as a demodulator does
  task automatic mark(input int k);
    @(posedge aclk);
    capture_input_main <= 1'h1;
    repeat (k) @(posedge aclk);
    capture_input_main <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* irt_timer_tb_top.sv */
// self-checking bench of the infrared dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module irt_timer_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, awready, wready, arready;
  logic [7:0] awaddr, araddr, rd;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  wire logic cim, cia;
  logic bop, bos, wop, wos, cop, cos, i0, i1, i2, i3;
  int n_mismatch, tests_run, n, t0;
  int n_bto, n_bcap, n_wto, n_wcap;
  irt_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .capture_input_main(cim), .capture_input_alt(cia),
    .byte_output_pin(bop), .byte_output_sel(bos), .word_output_pin(wop), .word_output_sel(wos),
    .combined_output_pin(cop), .combined_output_sel(cos), .byte_timeout_irq(i0), .byte_capture_irq(i1),
    .word_timeout_irq(i2), .word_capture_irq(i3));
  irt_ir_far u_far (.aclk(aclk), .capture_input_main(cim), .capture_input_alt(cia));
  // interrupt lines are one-cycle pulses, so they are counted rather than polled
  always @(posedge aclk) begin
    if (i0) n_bto++;
    if (i1) n_bcap++;
    if (i2) n_wto++;
    if (i3) n_wcap++;
  end
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready and the answer are read as they stood at the rising edge just passed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      tb = bvalid;
    end
    bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      tr = rvalid;
      rd = rdata[7:0];
      rs = rresp;
    end
    rready <= 1'h0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    seed = 32'h11B5;
    aresetn = 1'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    chk(bop, 1);
    chk(wop, 1);
    rdr(irt_pkg::OFS_BCTL);
    chk(rd, 0);
    chk(rs, irt_pkg::RESP_OKAY);
    rdr(8'h2C);
    chk(rs, irt_pkg::RESP_SLVERR);
    chk(rd, 0);
    // byte out 0 and word out 1 while disabled, so the four combines give 0,1,0,1
    for (int c = 0; c < 4; c++) begin
      wr(irt_pkg::OFS_SCTL, 8'h42 | 8'(c << 4));
      repeat (3) @(posedge aclk);
      chk(bop, 0);
      chk(cos, 1);
      chk(cop, c % 2);
    end
    wr(irt_pkg::OFS_SCTL, 8'h08);
    repeat (3) @(posedge aclk);
    chk(wop, 0);
    wr(irt_pkg::OFS_SCTL, 8'h0C);
    repeat (3) @(posedge aclk);
    chk(wop, 1);
    wr(irt_pkg::OFS_SCTL, 8'h00);
    seed = xs(seed);
    n = 8 + int'(seed[4:0]);
    wr(irt_pkg::OFS_BRH, 8'h03);
    wr(irt_pkg::OFS_BRL, 8'(n));
    wr(irt_pkg::OFS_BCTL, 8'hC3);
    t0 = $time;
    // the pin register follows the enable one edge later
    @(posedge aclk);
    chk(bop, 0);
    chk(bos, 1);
    rd = 8'h00;
    for (int p = 0; p < 100 && !rd[5]; p++) rdr(irt_pkg::OFS_BCTL);
    chk(rd[7:5], 3'h3);
    chk(bop, 1);
    chk(($time - t0) / 5 >= n, 1);
    chk(n_bto, 1);
    wr(irt_pkg::OFS_BCTL, 8'h20);
    rdr(irt_pkg::OFS_BCTL);
    chk(rd[5], 0);
    // word timer single pass on the divide-by-two clock
    wr(irt_pkg::OFS_WRU, 8'h00);
    wr(irt_pkg::OFS_WRL, 8'(n));
    wr(irt_pkg::OFS_WCTL, 8'hCB);
    t0 = $time;
    rd = 8'h00;
    for (int p = 0; p < 100 && !rd[5]; p++) rdr(irt_pkg::OFS_WCTL);
    chk(rd[7:5], 3'h3);
    chk(n_wto, 1);
    chk(($time - t0) / 10 >= n, 1);
    chk(wos, 1);
    chk(wop, 1);
    wr(irt_pkg::OFS_WCTL, 8'h20);
    // ping-pong: the byte timer runs first, then hands over to the word timer
    wr(irt_pkg::OFS_SCTL, 8'h04);
    wr(irt_pkg::OFS_WCTL, 8'h40);
    wr(irt_pkg::OFS_BCTL, 8'hC0);
    rd = 8'h00;
    for (int p = 0; p < 100 && !rd[7]; p++) rdr(irt_pkg::OFS_WCTL);
    rdr(irt_pkg::OFS_BCTL);
    chk(rd[7:5], 3'h3);
    wr(irt_pkg::OFS_SCTL, 8'h00);
    repeat (100) @(posedge aclk);
    rdr(irt_pkg::OFS_BCTL);
    chk(rd[7], 0);
    rdr(irt_pkg::OFS_WCTL);
    chk(rd[7], 0);
    wr(irt_pkg::OFS_BRH, 8'hFF);
    wr(irt_pkg::OFS_BRL, 8'hFF);
    wr(irt_pkg::OFS_SCTL, 8'hB0);
    wr(irt_pkg::OFS_BCTL, 8'h84);
    wr(irt_pkg::OFS_WCTL, 8'h84);
    seed = xs(seed);
    n = 20 + int'(seed[5:0]);
    // rise starts the count, the fall is captured as a complement
    u_far.mark(n);
    repeat (8) @(posedge aclk);
    rdr(irt_pkg::OFS_BCF);
    chk(int'(rd) >= n - 2 && int'(rd) <= n + 2, 1);
    rdr(irt_pkg::OFS_WCL);
    chk(int'(rd) >= n - 2 && int'(rd) <= n + 2, 1);
    rdr(irt_pkg::OFS_WCU);
    chk(rd, 0);
    chk(n_bcap, 1);
    chk(n_wcap, 2);
    rdr(irt_pkg::OFS_SCTL);
    chk(rd[0], 1);
    wr(irt_pkg::OFS_SCTL, 8'hB0);
    rdr(irt_pkg::OFS_SCTL);
    chk(rd[0], 1);
    wr(irt_pkg::OFS_SCTL, 8'hB1);
    rdr(irt_pkg::OFS_SCTL);
    chk(rd[0], 0);
    end_of_test;
  end
endmodule
`default_nettype wire
